// [exb_cfg.svh]
// Purpose: shared constants for the expansion bus cycle-timing block
// Assumes: phase lengths arrive encoded as cycle count minus one
// Notes: included by every design file that needs a fixed figure
`ifndef EXB_CFG_SVH
`define EXB_CFG_SVH

// width of the phase down-counter, enough for a 16-cycle phase
`define EXB_CNT_W 4
// ale-low address hold is fixed at one bus cycle, loaded as count minus one
`define EXB_ALE_HOLD_LEN 4'h0
// counter value that marks the last cycle of a phase
`define EXB_CNT_LAST 4'h0
// flip-flop stages in every synchroniser
`define EXB_SYNC_STAGES 2
// cycles between sampling the pin and the synchronised copy being valid
`define EXB_RD_LAT 2
// idle levels of the pins, the output enable level, and the reset value of the toggles
`define EXB_STROBE_IDLE 1'b1
`define EXB_CS_IDLE 1'b1
`define EXB_ALE_IDLE 1'b0
`define EXB_OE_OFF 1'b1
`define EXB_OE_ON 1'b0
`define EXB_TGL_RST 1'b0

`endif

// [exb_muxed_timing.sv]
// Purpose: expansion bus master cycle generator, muxed and simplex modes
// Assumes: requests come in on core_clk_in; the pins run on bus_clock_in
// Notes: phase lengths are cycles minus one; a request crosses by toggle
// Notes on behaviour
// - address latch enable stays low in simplex
// - address phase length sets address cycles
// - setup length sets data cycles before strobe
// - strobe length sets strobe low time
// - hold length keeps select, address, data
// - recovery length sets idle gap between accesses
// - latch enable pulses one to four cycles
// - address held one cycle after latch falls
// - write data valid setup cycles before strobe
`timescale 1ns/1ps
`include "exb_cfg.svh"

module exb_muxed_timing
	import exb_pkg::*;
#(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic bus_clock_in,
	// core side request and answer
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [ADDR_W-1:0] req_addr_in,
	input wire logic [DATA_W-1:0] req_wdata_in,
	output logic req_ready_out,
	output logic done_out,
	output logic [DATA_W-1:0] rdata_out,
	// configuration, sampled with each request
	input wire logic muxed_mode_in,
	input wire logic [1:0] address_phase_len_in,
	input wire logic [1:0] setup_phase_len_in,
	input wire logic [3:0] strobe_phase_len_in,
	input wire logic [1:0] hold_phase_len_in,
	input wire logic [3:0] recovery_phase_len_in,
	// expansion bus pins
	output logic addr_latch_enable_out,
	output logic chip_select_n_out,
	output logic [ADDR_W-1:0] bus_addr_out,
	output logic read_strobe_n_out,
	output logic write_strobe_n_out,
	input wire logic [DATA_W-1:0] muxed_addr_data_bus_in,
	output logic [DATA_W-1:0] muxed_addr_data_bus_out,
	output logic muxed_addr_data_bus_oe_n_out
);

	localparam int CNT_W = `EXB_CNT_W;

	// ---------------- core domain ----------------
	logic busy;
	logic req_tgl;
	logic ack_seen;
	logic ack_tgl_sync;
	logic c_write;
	logic c_muxed;
	logic [ADDR_W-1:0] c_addr;
	logic [DATA_W-1:0] c_wdata;
	logic [1:0] c_addr_len;
	logic [1:0] c_setup_len;
	logic [3:0] c_strobe_len;
	logic [1:0] c_hold_len;
	logic [3:0] c_recov_len;
	logic accept;
	logic ack_arrived;
	logic [DATA_W-1:0] l_rdata;

	// words handed to the link side are held until the access is answered
	assign accept = req_valid_in && !busy;
	assign ack_arrived = (ack_tgl_sync != ack_seen);

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			c_write <= 1'b0;
			c_muxed <= 1'b0;
			c_addr <= '0;
			c_wdata <= '0;
			c_addr_len <= 2'h0;
			c_setup_len <= 2'h0;
			c_strobe_len <= 4'h0;
			c_hold_len <= 2'h0;
			c_recov_len <= 4'h0;
		end else if (accept) begin
			c_write <= req_write_in;
			c_muxed <= muxed_mode_in;
			c_addr <= req_addr_in;
			c_wdata <= req_wdata_in;
			c_addr_len <= address_phase_len_in;
			c_setup_len <= setup_phase_len_in;
			c_strobe_len <= strobe_phase_len_in;
			c_hold_len <= hold_phase_len_in;
			c_recov_len <= recovery_phase_len_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			busy <= 1'b0;
			req_tgl <= `EXB_TGL_RST;
			ack_seen <= `EXB_TGL_RST;
		end else begin
			if (accept) begin
				busy <= 1'b1;
				req_tgl <= !req_tgl;
			end else if (ack_arrived) begin
				busy <= 1'b0;
			end
			if (ack_arrived) begin
				ack_seen <= ack_tgl_sync;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			req_ready_out <= 1'b0;
			done_out <= 1'b0;
			rdata_out <= '0;
		end else begin
			req_ready_out <= !(busy || accept) || (ack_arrived && !accept);
			done_out <= ack_arrived;
			if (ack_arrived && !c_write) begin
				rdata_out <= l_rdata;
			end
		end
	end

	// ---------------- link domain ----------------
	logic link_rst;
	logic req_tgl_sync;
	logic req_seen;
	logic ack_tgl;
	logic [DATA_W-1:0] pin_data_sync;
	logic [`EXB_RD_LAT-1:0] rd_pipe;
	logic l_write;
	logic l_muxed;
	logic [ADDR_W-1:0] l_addr;
	logic [DATA_W-1:0] l_wdata;
	logic [1:0] l_addr_len;
	logic [1:0] l_setup_len;
	logic [3:0] l_strobe_len;
	logic [1:0] l_hold_len;
	logic [3:0] l_recov_len;
	exb_state_t state;
	exb_state_t next_state;
	logic phase_last;
	logic tmr_load;
	logic [CNT_W-1:0] tmr_val;
	logic req_pending;

	exb_sync #(.WIDTH(1)) u_rst_sync (
		.clk_in(bus_clock_in),
		.d_in(sys_rst_in),
		.q_out(link_rst)
	);

	exb_sync #(.WIDTH(1)) u_req_sync (
		.clk_in(bus_clock_in),
		.d_in(req_tgl),
		.q_out(req_tgl_sync)
	);

	exb_sync #(.WIDTH(1)) u_ack_sync (
		.clk_in(core_clk_in),
		.d_in(ack_tgl),
		.q_out(ack_tgl_sync)
	);

	exb_sync #(.WIDTH(DATA_W)) u_pin_sync (
		.clk_in(bus_clock_in),
		.d_in(muxed_addr_data_bus_in),
		.q_out(pin_data_sync)
	);

	exb_phase_timer #(.CNT_W(CNT_W)) u_timer (
		.clk_in(bus_clock_in),
		.rst_in(link_rst),
		.load_in(tmr_load),
		.load_val_in(tmr_val),
		.last_out(phase_last)
	);

	assign req_pending = (req_tgl_sync != req_seen);

	// length, minus one, of the phase about to start
	function automatic logic [CNT_W-1:0] phase_len(input exb_state_t st);
		unique case (st)
			ST_ADDR: phase_len = CNT_W'(l_addr_len);
			ST_ALE_HOLD: phase_len = CNT_W'(`EXB_ALE_HOLD_LEN);
			ST_SETUP: phase_len = CNT_W'(l_setup_len);
			ST_STROBE: phase_len = CNT_W'(l_strobe_len);
			ST_HOLD: phase_len = CNT_W'(l_hold_len);
			ST_RECOV: phase_len = CNT_W'(l_recov_len);
			ST_IDLE: phase_len = CNT_W'(`EXB_CNT_LAST);
		endcase
	endfunction

	// select is active from the cycle after the latch falls through hold, or from the address phase in simplex
	function automatic logic cs_active(input exb_state_t st, input logic muxed);
		cs_active = (st == ST_SETUP) || (st == ST_STROBE) || (st == ST_HOLD)
			|| (st == ST_ALE_HOLD) || ((st == ST_ADDR) && !muxed);
	endfunction

	function automatic logic in_access(input exb_state_t st);
		in_access = (st != ST_IDLE) && (st != ST_RECOV);
	endfunction

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: if (req_pending) next_state = ST_ADDR;
			ST_ADDR: if (phase_last) next_state = l_muxed ? ST_ALE_HOLD : ST_SETUP;
			ST_ALE_HOLD: if (phase_last) next_state = ST_SETUP;
			ST_SETUP: if (phase_last) next_state = ST_STROBE;
			ST_STROBE: if (phase_last) next_state = ST_HOLD;
			ST_HOLD: if (phase_last) next_state = ST_RECOV;
			ST_RECOV: if (phase_last) next_state = ST_IDLE;
		endcase
		// kept in the process so a change of the held lengths is seen at once
		tmr_load = (next_state != state);
		tmr_val = phase_len(next_state);
	end

	always_ff @(posedge bus_clock_in) begin
		if (link_rst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// mirror the request words while idle; they settle before the toggle lands,
	// so the first address cycle already uses the new request
	always_ff @(posedge bus_clock_in) begin
		if (link_rst) begin
			req_seen <= `EXB_TGL_RST;
			l_write <= 1'b0;
			l_muxed <= 1'b0;
			l_addr <= '0;
			l_wdata <= '0;
			l_addr_len <= 2'h0;
			l_setup_len <= 2'h0;
			l_strobe_len <= 4'h0;
			l_hold_len <= 2'h0;
			l_recov_len <= 4'h0;
		end else if (state == ST_IDLE) begin
			if (req_pending) begin
				req_seen <= req_tgl_sync;
			end
			l_write <= c_write;
			l_muxed <= c_muxed;
			l_addr <= c_addr;
			l_wdata <= c_wdata;
			l_addr_len <= c_addr_len;
			l_setup_len <= c_setup_len;
			l_strobe_len <= c_strobe_len;
			l_hold_len <= c_hold_len;
			l_recov_len <= c_recov_len;
		end
	end

	// answer only after recovery has run out
	always_ff @(posedge bus_clock_in) begin
		if (link_rst) begin
			ack_tgl <= `EXB_TGL_RST;
		end else if (state == ST_RECOV && phase_last) begin
			ack_tgl <= !ack_tgl;
		end
	end

	// read data at the strobe's rising edge, allowing for synchroniser delay
	always_ff @(posedge bus_clock_in) begin
		if (link_rst) begin
			rd_pipe <= '0;
			l_rdata <= '0;
		end else begin
			rd_pipe <= {rd_pipe[`EXB_RD_LAT-2:0], (state == ST_STROBE) && phase_last && !l_write};
			if (rd_pipe[`EXB_RD_LAT-1]) begin
				l_rdata <= pin_data_sync;
			end
		end
	end

	// pins are registered from the next state so they line up with it
	always_ff @(posedge bus_clock_in) begin
		if (link_rst) begin
			addr_latch_enable_out <= `EXB_ALE_IDLE;
			chip_select_n_out <= `EXB_CS_IDLE;
		end else begin
			addr_latch_enable_out <= (next_state == ST_ADDR) && l_muxed;
			chip_select_n_out <= !cs_active(next_state, l_muxed);
		end
	end

	always_ff @(posedge bus_clock_in) begin
		if (link_rst) begin
			bus_addr_out <= '0;
		end else if (in_access(next_state)) begin
			bus_addr_out <= l_addr;
		end
	end

	always_ff @(posedge bus_clock_in) begin
		if (link_rst) begin
			read_strobe_n_out <= `EXB_STROBE_IDLE;
			write_strobe_n_out <= `EXB_STROBE_IDLE;
		end else if (l_muxed) begin
			// read pin carries direction, write pin the data strobe
			read_strobe_n_out <= in_access(next_state) ? !l_write : `EXB_STROBE_IDLE;
			write_strobe_n_out <= !(next_state == ST_STROBE);
		end else begin
			read_strobe_n_out <= !((next_state == ST_STROBE) && !l_write);
			write_strobe_n_out <= !((next_state == ST_STROBE) && l_write);
		end
	end

	always_ff @(posedge bus_clock_in) begin
		if (link_rst) begin
			muxed_addr_data_bus_out <= '0;
			muxed_addr_data_bus_oe_n_out <= `EXB_OE_OFF;
		end else if (l_muxed && (next_state == ST_ADDR || next_state == ST_ALE_HOLD)) begin
			muxed_addr_data_bus_out <= l_addr[DATA_W-1:0];
			muxed_addr_data_bus_oe_n_out <= `EXB_OE_ON;
		end else if (l_write && (next_state == ST_SETUP || next_state == ST_STROBE
			|| next_state == ST_HOLD)) begin
			muxed_addr_data_bus_out <= l_wdata;
			muxed_addr_data_bus_oe_n_out <= `EXB_OE_ON;
		end else begin
			muxed_addr_data_bus_oe_n_out <= `EXB_OE_OFF;
		end
	end

endmodule

// [exb_muxed_timing_sva.sv]
// Purpose: pin timing checks for the expansion cycle generator
// Assumes: request fields and lengths stay steady until done_out
// Notes: lengths arrive as cycles minus one
`timescale 1ns/1ps
module exb_muxed_timing_sva #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16
) (
	input wire logic bus_clock_in,
	input wire logic sys_rst_in,
	input wire logic muxed_mode_in,
	input wire logic req_write_in,
	input wire logic [ADDR_W-1:0] req_addr_in,
	input wire logic [DATA_W-1:0] req_wdata_in,
	input wire logic [1:0] address_phase_len_in,
	input wire logic [1:0] setup_phase_len_in,
	input wire logic [3:0] strobe_phase_len_in,
	input wire logic [1:0] hold_phase_len_in,
	input wire logic [3:0] recovery_phase_len_in,
	input wire logic addr_latch_enable_out,
	input wire logic chip_select_n_out,
	input wire logic [ADDR_W-1:0] bus_addr_out,
	input wire logic read_strobe_n_out,
	input wire logic write_strobe_n_out,
	input wire logic [DATA_W-1:0] muxed_addr_data_bus_out,
	input wire logic muxed_addr_data_bus_oe_n_out
);
	wire ale = addr_latch_enable_out;
	wire csn = chip_select_n_out;
	wire dsn = write_strobe_n_out;
	wire oen = muxed_addr_data_bus_oe_n_out;
	wire mx = muxed_mode_in;
	wire [DATA_W-1:0] bo = muxed_addr_data_bus_out;
	logic [4:0] ale_n, pre_n, ds_n, post_n, gap_n;
	logic [3:0] rec_q;
	logic [1:0] rst_q;
	// reset as the bus side sees it, two bus edges behind the core reset
	wire bus_rst = sys_rst_in || rst_q[1];
	default clocking @(posedge bus_clock_in); endclocking
	default disable iff (bus_rst);
	always_ff @(posedge bus_clock_in) begin
		rst_q <= {rst_q[0], sys_rst_in};
	end
	// phase counters, each counts cycles of one pin condition, and rec_q, the recovery length taken while select is low
	always_ff @(posedge bus_clock_in) begin
		if (bus_rst) begin
			ale_n <= 5'h00;
			pre_n <= 5'h00;
			ds_n <= 5'h00;
			post_n <= 5'h00;
			gap_n <= 5'h1f;
			rec_q <= 4'h0;
		end else begin
			ale_n <= ale ? ale_n + 5'h01 : 5'h00;
			ds_n <= !dsn ? ds_n + 5'h01 : 5'h00;
			pre_n <= csn ? 5'h00 : pre_n + {4'h0, dsn};
			post_n <= !dsn ? 5'h00 : post_n + {4'h0, !csn};
			gap_n <= (csn && !ale) ? gap_n + {4'h0, gap_n != 5'h1f} : 5'h00;
			rec_q <= csn ? rec_q : recovery_phase_len_in;
		end
	end
	sequence ale_end;
		$fell(ale);
	endsequence
	sequence ds_end;
		$rose(dsn);
	endsequence
	a_simplex_ale_low: assert property (!mx |-> !ale)
		else $error("latch enable high in simplex");
	a_ale_addr_len: assert property (ale_end |->
		ale_n == 5'(address_phase_len_in) + 5'h01) else $error("latch pulse length wrong");
	a_ale_addr_val: assert property (ale |-> !oen &&
		bo == req_addr_in[DATA_W-1:0] && bus_addr_out == req_addr_in) else $error("address bad");
	a_addr_hold_one: assert property (ale_end |->
		(!oen && !csn && $stable(bo)) ##1 (req_write_in || oen)) else $error("address hold bad");
	a_setup_len: assert property (mx && $fell(dsn) |->
		pre_n == 5'(setup_phase_len_in) + 5'h02) else $error("setup length wrong");
	a_wdata_valid: assert property (mx && req_write_in && $fell(dsn) |->
		$past(bo) == req_wdata_in && !$past(oen)) else $error("write data late");
	a_strobe_len: assert property (mx ##0 ds_end |->
		ds_n == 5'(strobe_phase_len_in) + 5'h01) else $error("strobe length wrong");
	a_hold_len: assert property (mx && $rose(csn) |->
		post_n == 5'(hold_phase_len_in) + 5'h01) else $error("hold length wrong");
	a_recov_gap: assert property ($rose(ale) |-> gap_n > 5'(rec_q))
		else $error("recovery gap short");
	a_rnw_dir: assert property (mx && (!csn || ale) |->
		read_strobe_n_out == !req_write_in) else $error("direction pin wrong");
	a_idle_quiet: assert property (csn && !ale |-> dsn && read_strobe_n_out && oen)
		else $error("pins not idle");
endmodule
bind exb_muxed_timing exb_muxed_timing_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (
	.bus_clock_in(bus_clock_in), .sys_rst_in(sys_rst_in), .muxed_mode_in(muxed_mode_in),
	.req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
	.address_phase_len_in(address_phase_len_in), .setup_phase_len_in(setup_phase_len_in),
	.strobe_phase_len_in(strobe_phase_len_in), .hold_phase_len_in(hold_phase_len_in),
	.recovery_phase_len_in(recovery_phase_len_in),
	.addr_latch_enable_out(addr_latch_enable_out), .chip_select_n_out(chip_select_n_out),
	.bus_addr_out(bus_addr_out), .read_strobe_n_out(read_strobe_n_out),
	.write_strobe_n_out(write_strobe_n_out),
	.muxed_addr_data_bus_out(muxed_addr_data_bus_out),
	.muxed_addr_data_bus_oe_n_out(muxed_addr_data_bus_oe_n_out));

// [exb_periph_model.sv]
// Purpose: peripheral on the expansion bus, answers reads, logs writes
// Assumes: no pull on the data lines, so released lines toggle
// Notes: read data is the low address xor 5a5a
`timescale 1ns/1ps
module exb_periph_model (
	input wire logic bus_clock_in,
	input wire logic muxed_in,
	input wire logic ale_in,
	input wire logic cs_n_in,
	input wire logic rnw_in,
	input wire logic ds_n_in,
	input wire logic oe_n_in,
	input wire logic [15:0] addr_in,
	input wire logic [15:0] data_in,
	output logic [15:0] wire_out,
	output logic [15:0] addr_out,
	output logic [15:0] wdata_out,
	output logic [7:0] len_out
);
	logic [15:0] junk = 16'h0f0f;
	logic [7:0] cnt = 8'h00;
	always_comb begin
		if (!oe_n_in)
			wire_out = data_in;
		else if (!cs_n_in && !ale_in && (rnw_in == muxed_in))
			wire_out = addr_in ^ 16'h5a5a;
		else
			wire_out = junk;
	end
	always_ff @(posedge bus_clock_in) begin
		junk <= ~wire_out;
		if (ale_in) addr_out <= wire_out;
		if (!ds_n_in && !(muxed_in && rnw_in)) wdata_out <= wire_out;
		cnt <= (ale_in || !cs_n_in) ? cnt + 8'h01 : 8'h00;
		if (cnt != 8'h00 && !ale_in && cs_n_in) len_out <= cnt;
	end
endmodule

// [exb_phase_timer.sv]
// Purpose: loadable down-counter that times one access phase
// Assumes: load value is the phase length in cycles minus one
// Notes: last_out is high in the final cycle of the phase
`timescale 1ns/1ps
`include "exb_cfg.svh"

module exb_phase_timer #(
	parameter int CNT_W = `EXB_CNT_W
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic load_in,
	input wire logic [CNT_W-1:0] load_val_in,
	output logic last_out
);

	logic [CNT_W-1:0] cnt;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt <= CNT_W'(`EXB_CNT_LAST);
		end else if (load_in) begin
			cnt <= load_val_in;
		end else if (cnt != CNT_W'(`EXB_CNT_LAST)) begin
			cnt <= cnt - CNT_W'(1);
		end
	end

	assign last_out = (cnt == CNT_W'(`EXB_CNT_LAST));

endmodule

// [exb_pkg.sv]
// Purpose: types for the expansion bus cycle-timing block
// Assumes: nothing beyond the shared constants header
// Notes: states follow the access phases in order
package exb_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ALE_HOLD,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_RECOV
	} exb_state_t;

endpackage

// [exb_sync.sv]
// Purpose: multi-stage level synchroniser into the destination clock
// Assumes: each bit is a level or a toggle; words cross only when stable
// Notes: only the last stage is meant to be read
`timescale 1ns/1ps
`include "exb_cfg.svh"

module exb_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] stage [`EXB_SYNC_STAGES];

	always_ff @(posedge clk_in) begin
		stage[0] <= d_in;
	end

	generate
		for (genvar i = 1; i < `EXB_SYNC_STAGES; i++) begin : g_stage
			always_ff @(posedge clk_in) begin
				stage[i] <= stage[i-1];
			end
		end
	endgenerate

	assign q_out = stage[`EXB_SYNC_STAGES-1];

endmodule

// [tb_exb_muxed_timing.sv]
// Purpose: self-checking bench for the expansion cycle generator
// Assumes: lengths and request fields held until done_out
// Notes: random fields come from a 16-bit shift register
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_exb_muxed_timing;
	// bus clock starts high so its rising edges never meet the core's
	logic core_clk_in = 1'b0, bus_clock_in = 1'b1, sys_rst_in = 1'b1;
	logic req_valid_in = 1'b0, req_write_in = 1'b0, muxed_mode_in = 1'b0;
	logic [23:0] req_addr_in = 24'h00_0000, bus_addr_out;
	logic [15:0] req_wdata_in = 16'h0000, lf = 16'h0062, addr_m, wd_m;
	logic [1:0] address_phase_len_in = 2'h0, setup_phase_len_in = 2'h0, hold_phase_len_in = 2'h0;
	logic [3:0] strobe_phase_len_in = 4'h0, recovery_phase_len_in = 4'h0;
	logic req_ready_out, done_out, addr_latch_enable_out, chip_select_n_out;
	logic read_strobe_n_out, write_strobe_n_out, muxed_addr_data_bus_oe_n_out;
	logic [15:0] rdata_out, muxed_addr_data_bus_in, muxed_addr_data_bus_out;
	logic [7:0] len_m;
	int error_cnt = 0, comparisons = 0;
	time lat, t_fast;
	always #12.5 core_clk_in = ~core_clk_in;
	always #7.5 bus_clock_in = ~bus_clock_in;
	exb_muxed_timing uut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.bus_clock_in(bus_clock_in), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
		.req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
		.done_out(done_out), .rdata_out(rdata_out), .muxed_mode_in(muxed_mode_in),
		.address_phase_len_in(address_phase_len_in), .setup_phase_len_in(setup_phase_len_in),
		.strobe_phase_len_in(strobe_phase_len_in), .hold_phase_len_in(hold_phase_len_in),
		.recovery_phase_len_in(recovery_phase_len_in),
		.addr_latch_enable_out(addr_latch_enable_out), .chip_select_n_out(chip_select_n_out),
		.bus_addr_out(bus_addr_out), .read_strobe_n_out(read_strobe_n_out),
		.write_strobe_n_out(write_strobe_n_out),
		.muxed_addr_data_bus_in(muxed_addr_data_bus_in),
		.muxed_addr_data_bus_out(muxed_addr_data_bus_out),
		.muxed_addr_data_bus_oe_n_out(muxed_addr_data_bus_oe_n_out));
	exb_periph_model pm (.bus_clock_in(bus_clock_in), .muxed_in(muxed_mode_in),
		.ale_in(addr_latch_enable_out), .cs_n_in(chip_select_n_out), .rnw_in(read_strobe_n_out),
		.ds_n_in(write_strobe_n_out), .oe_n_in(muxed_addr_data_bus_oe_n_out),
		.addr_in(bus_addr_out[15:0]), .data_in(muxed_addr_data_bus_out),
		.wire_out(muxed_addr_data_bus_in), .addr_out(addr_m), .wdata_out(wd_m), .len_out(len_m));
	function automatic logic [15:0] nxt(input logic [15:0] v);
		repeat (16) v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
		return v;
	endfunction
	function automatic logic [7:0] exp_len(input logic m, input logic [1:0] a, s, h,
		input logic [3:0] d);
		return 8'(a) + 8'(s) + 8'(d) + 8'(h) + 8'h04 + 8'(m);
	endfunction
	task automatic conclude();
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic access(input logic w, m, input logic [1:0] a, s, h, input logic [3:0] d, r,
		input logic [23:0] adr, input logic [15:0] dat);
		int n;
		time t0;
		n = 0;
		do @(posedge core_clk_in); while (req_ready_out !== 1'b1 && n++ < 300);
		req_valid_in <= 1'b1;
		req_write_in <= w;
		muxed_mode_in <= m;
		address_phase_len_in <= a;
		setup_phase_len_in <= s;
		strobe_phase_len_in <= d;
		hold_phase_len_in <= h;
		recovery_phase_len_in <= r;
		req_addr_in <= adr;
		req_wdata_in <= dat;
		t0 = $time;
		@(posedge core_clk_in);
		req_valid_in <= 1'b0;
		n = 0;
		do @(posedge core_clk_in); while (done_out !== 1'b1 && n++ < 2000);
		lat = $time - t0;
		`CHK(done_out, 1'b1)
		if (!w) `CHK(rdata_out, adr[15:0] ^ 16'h5a5a)
		else `CHK(wd_m, dat)
		`CHK(len_m, exp_len(m, a, s, h, d))
		if (m) `CHK(addr_m, adr[15:0])
	endtask
	initial begin
		logic [31:0] rv;
		repeat (20) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		repeat (4) @(posedge bus_clock_in);
		access(1'b1, 1'b1, 2'h0, 2'h0, 2'h0, 4'h0, 4'h0, 24'h00_1234, 16'hbeef);
		access(1'b0, 1'b1, 2'h3, 2'h3, 2'h3, 4'hf, 4'hf, 24'hff_ffff, 16'h0000);
		access(1'b1, 1'b0, 2'h3, 2'h0, 2'h3, 4'h2, 4'h1, 24'h12_3456, 16'h55aa);
		access(1'b0, 1'b0, 2'h0, 2'h3, 2'h0, 4'hf, 4'h0, 24'hab_cdef, 16'h0000);
		$display("test corner lengths done");
		access(1'b0, 1'b1, 2'h1, 2'h1, 2'h1, 4'h1, 4'h0, 24'h00_0f0f, 16'h0000);
		t_fast = lat;
		access(1'b0, 1'b1, 2'h1, 2'h1, 2'h1, 4'h1, 4'hf, 24'h00_0f0f, 16'h0000);
		`CHK(lat >= t_fast + 185, 1'b1)
		$display("test recovery gap done");
		repeat (24) begin
			lf = nxt(lf);
			rv[15:0] = lf;
			lf = nxt(lf);
			rv[31:16] = lf;
			access(rv[0], rv[1], rv[3:2], rv[5:4], rv[7:6], rv[11:8], rv[15:12],
				{rv[31:24], rv[23:8]}, rv[31:16]);
		end
		$display("test random accesses done");
		conclude();
	end
	initial begin
		#300000;
		error_cnt++;
		$display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		conclude();
	end
endmodule
